// ===== inc/isp_pkg.sv
// Notes on behaviour
// - Serial link works only while reset pin low
// - Nothing except poll executes before programming enable accepted
// - EEPROM byte write self-erases, one byte each
// - Chip erase sets flash and EEPROM to FF
// - Input bits sampled on serial clock rise
// - Output bits shifted on serial clock fall
// - Second enable byte echoed during third byte
// - Extended address byte kept until reloaded
// - Reads return data in fourth byte
// - Poll returns busy in status bit zero
// - Decode enable and chip erase instructions
// - Decode extended address and buffer load instructions
// - Decode flash, EEPROM, signature, calibration reads
// - Decode lock and fuse reads
// - Decode page write and EEPROM writes
// - Write lock and fuse bytes, zero programmed
// - Program memory addresses are word addresses
package isp_pkg;

    localparam real CORE_CLK_MHZ   = 100.0;
    localparam real FLASH_WAIT_MS  = 4.5;
    localparam real EEPROM_WAIT_MS = 9.0;
    localparam real ERASE_WAIT_MS  = 9.0;
    localparam int  FLASH_WAIT_CYC  = int'($ceil(FLASH_WAIT_MS * CORE_CLK_MHZ * 1000.0));
    localparam int  EEPROM_WAIT_CYC = int'($ceil(EEPROM_WAIT_MS * CORE_CLK_MHZ * 1000.0));
    localparam int  ERASE_WAIT_CYC  = int'($ceil(ERASE_WAIT_MS * CORE_CLK_MHZ * 1000.0));
    localparam int  WAIT_W          = 20;

    localparam int FLASH_AW_DEF   = 15;
    localparam int PAGE_AW_DEF    = 7;
    localparam int EE_AW_DEF      = 11;
    localparam int EE_PAGE_AW_DEF = 2;
    localparam int ADDR_W         = 24;

    localparam logic [4:0] HDR_LAST_BIT   = 5'h17;
    localparam logic [4:0] INSTR_LAST_BIT = 5'h1F;
    localparam logic [4:0] RESP_LOAD_BIT  = 5'h18;

    localparam logic [7:0] OP_CTRL        = 8'hAC;
    localparam logic [7:0] SUB_ENABLE     = 8'h53;
    localparam logic [7:0] SUB_ERASE      = 8'h80;
    localparam logic [7:0] SUB_WR_LOCK    = 8'hE0;
    localparam logic [7:0] SUB_WR_FUSE_LO = 8'hA0;
    localparam logic [7:0] SUB_WR_FUSE_HI = 8'hA8;
    localparam logic [7:0] SUB_WR_FUSE_EX = 8'hA4;
    localparam logic [7:0] SUB_FUSE_UPPER = 8'h08;
    localparam logic [7:0] OP_POLL        = 8'hF0;
    localparam logic [7:0] OP_LD_EXT      = 8'h4D;
    localparam logic [7:0] OP_LD_HI       = 8'h48;
    localparam logic [7:0] OP_LD_LO       = 8'h40;
    localparam logic [7:0] OP_LD_EE_PAGE  = 8'hC1;
    localparam logic [7:0] OP_RD_HI       = 8'h28;
    localparam logic [7:0] OP_RD_LO       = 8'h20;
    localparam logic [7:0] OP_RD_EE       = 8'hA0;
    localparam logic [7:0] OP_RD_LOCK_FHI = 8'h58;
    localparam logic [7:0] OP_RD_FUSE     = 8'h50;
    localparam logic [7:0] OP_RD_SIG      = 8'h30;
    localparam logic [7:0] OP_RD_CAL      = 8'h38;
    localparam logic [7:0] OP_WR_PAGE     = 8'h4C;
    localparam logic [7:0] OP_WR_EE       = 8'hC0;
    localparam logic [7:0] OP_WR_EE_PAGE  = 8'hC2;

    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0]  NO_DATA     = 8'h00;

    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } isp_header_t;

    typedef struct packed {
        isp_header_t hdr;
        logic [7:0]  b4;
    } isp_instr_t;

    typedef enum logic [1:0] {CORE_IDLE, CORE_TIMED, CORE_ERASE} core_state_t;

    typedef struct packed {
        logic [4:0]  bit_cnt;
        logic [31:0] word;
        isp_header_t hdr;
        isp_instr_t  instr;
        logic        hdr_tgl;
        logic        exec_tgl;
    } link_rx_t;

    typedef struct packed {
        logic [7:0] tx;
    } link_tx_t;

    typedef struct packed {
        logic pin_n;
        logic hdr_tgl;
        logic exec_tgl;
    } sync_bits_t;

    typedef struct packed {
        core_state_t       state;
        logic              prog_en;
        logic              busy;
        logic              out_en;
        logic              hdr_seen;
        logic              exec_seen;
        logic [WAIT_W-1:0] wait_cnt;
        logic [ADDR_W-1:0] erase_ptr;
        logic [7:0]        ext_addr;
        logic [7:0]        resp;
        logic [7:0]        lock;
        logic [7:0]        fuse_lo;
        logic [7:0]        fuse_hi;
        logic [7:0]        fuse_ext;
    } core_t;

endpackage

// ===== src/bit_sync.sv
module bit_sync
    import isp_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset,
    // Levels in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_stage_t;

    sync_stage_t st;
    sync_stage_t next_st;

    always_comb
    begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            st <= '0;
        else
            st <= next_st;
    end

    assign q = st.s2;
endmodule // bit_sync

// ===== src/isp_link.sv
module isp_link
    import isp_pkg::*;
(
    // Serial pins
    input  wire logic  serial_clk,
    input  wire logic  reset_pin_n,
    input  wire logic  serial_data_in,
    output logic       serial_data_out,
    // Core side
    input  wire logic [7:0] resp,
    output isp_header_t     hdr,
    output isp_instr_t      instr,
    output logic            hdr_tgl,
    output logic            exec_tgl
);
    link_rx_t    rx;
    link_rx_t    next_rx;
    link_tx_t    tx;
    link_tx_t    next_tx;
    logic [31:0] word_in;

    always_comb
    begin
        word_in         = {rx.word[30:0], serial_data_in};
        next_rx         = rx;
        next_rx.bit_cnt = rx.bit_cnt + 5'h01;
        next_rx.word    = word_in;
        if (rx.bit_cnt == HDR_LAST_BIT)
        begin
            next_rx.hdr     = word_in[23:0];
            next_rx.hdr_tgl = ~rx.hdr_tgl;
        end
        if (rx.bit_cnt == INSTR_LAST_BIT)
        begin
            next_rx.instr    = word_in;
            next_rx.exec_tgl = ~rx.exec_tgl;
        end
    end

    // Clock may stop; the pin itself clears the frame position
    always_ff @(posedge serial_clk or posedge reset_pin_n)
    begin
        if (reset_pin_n)
            rx <= '0;
        else
            rx <= next_rx;
    end

    // Fourth byte takes the core answer, others echo the last byte
    always_comb
    begin
        next_tx.tx = {tx.tx[6:0], 1'b0};
        if (rx.bit_cnt[2:0] == 3'h0)
            next_tx.tx = (rx.bit_cnt == RESP_LOAD_BIT) ? resp : rx.word[7:0];
    end

    always_ff @(negedge serial_clk or posedge reset_pin_n)
    begin
        if (reset_pin_n)
            tx <= '0;
        else
            tx <= next_tx;
    end

    assign serial_data_out = tx.tx[7];
    assign hdr             = rx.hdr;
    assign instr           = rx.instr;
    assign hdr_tgl         = rx.hdr_tgl;
    assign exec_tgl        = rx.exec_tgl;

    property p_echo;
        @(negedge serial_clk) disable iff (reset_pin_n)
        rx.bit_cnt == 5'h10 |=> serial_data_out == $past(rx.word[7]);
    endproperty
    a_echo: assert property (p_echo) else $error("second byte not echoed");

    property p_capture;
        @(posedge serial_clk) disable iff (reset_pin_n)
        rx.bit_cnt == INSTR_LAST_BIT |=> instr.b4[0] == $past(serial_data_in)
            && instr.hdr.b1 == $past(rx.word[30:23]);
    endproperty
    a_capture: assert property (p_capture) else $error("instruction capture wrong");
endmodule // isp_link

// ===== src/isp_engine.sv
module isp_engine
    import isp_pkg::*;
#(
    parameter int          FLASH_AW    = FLASH_AW_DEF,
    parameter int          PAGE_AW     = PAGE_AW_DEF,
    parameter int          EE_AW       = EE_AW_DEF,
    parameter int          EE_PAGE_AW  = EE_PAGE_AW_DEF,
    parameter int unsigned FLASH_WAIT  = FLASH_WAIT_CYC,
    parameter int unsigned EEPROM_WAIT = EEPROM_WAIT_CYC,
    parameter int unsigned ERASE_WAIT  = ERASE_WAIT_CYC,
    // Identity values are arbitrary
    parameter logic [23:0] SIGNATURE   = 24'h030201,
    parameter logic [7:0]  CALIBRATION = 8'h80,
    parameter logic [7:0]  LOCK_INIT   = 8'hFF,
    parameter logic [7:0]  FUSE_LO_INIT  = 8'hFF,
    parameter logic [7:0]  FUSE_HI_INIT  = 8'hFF,
    parameter logic [7:0]  FUSE_EXT_INIT = 8'hFF
)
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Serial programming pins
    input  wire logic       serial_clk,
    input  wire logic       reset_pin_n,
    input  wire logic       serial_data_in,
    output logic            serial_data_out,
    output logic            serial_data_out_en,
    // Status
    output logic            prog_enabled,
    output logic            ready_busy_flag,
    output logic [3:0]      clock_source_fuses,
    output logic [7:0]      lock_bits
);
    localparam int FLASH_DEPTH   = 1 << FLASH_AW;
    localparam int EE_DEPTH      = 1 << EE_AW;
    localparam int PAGE_WORDS    = 1 << PAGE_AW;
    localparam int EE_PAGE_BYTES = 1 << EE_PAGE_AW;
    // Erase walks the larger array; a smaller flash wraps onto erased words, EEPROM stops at its depth
    localparam int ERASE_DEPTH = (FLASH_DEPTH > EE_DEPTH) ? FLASH_DEPTH : EE_DEPTH;
    localparam logic [ADDR_W-1:0] ERASE_LAST = ADDR_W'(ERASE_DEPTH - 1);
    localparam logic [ADDR_W-1:0] EE_LIMIT   = ADDR_W'(EE_DEPTH);

    core_t       st;
    core_t       next_st;
    sync_bits_t  sync_in;
    sync_bits_t  sync_q;
    isp_header_t hdr;
    isp_instr_t  instr;
    logic        hdr_tgl;
    logic        exec_tgl;
    logic        hdr_ev;
    logic        exec_ev;
    logic        run_ev;
    logic        pin_hi;
    logic [7:0]  resp_val;
    logic [15:0] fl_rd_word;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [EE_AW-1:0]  ee_rd_addr;
    logic [EE_AW-1:0]  ee_wr_addr;

    logic fbuf_lo_we;
    logic fbuf_hi_we;
    logic fl_page_we;
    logic ee_we;
    logic eebuf_we;
    logic ee_page_we;
    logic erase_we;

    logic [15:0] flash_mem [FLASH_DEPTH];
    logic [7:0]  ee_mem    [EE_DEPTH];
    logic [15:0] fbuf      [PAGE_WORDS];
    logic [7:0]  eebuf     [EE_PAGE_BYTES];
    logic [EE_PAGE_BYTES-1:0] eebuf_vld;

    isp_link u_link (
        .serial_clk      (serial_clk),
        .reset_pin_n     (reset_pin_n),
        .serial_data_in  (serial_data_in),
        .serial_data_out (serial_data_out),
        .resp            (st.resp),
        .hdr             (hdr),
        .instr           (instr),
        .hdr_tgl         (hdr_tgl),
        .exec_tgl        (exec_tgl)
    );

    assign sync_in.pin_n    = reset_pin_n;
    assign sync_in.hdr_tgl  = hdr_tgl;
    assign sync_in.exec_tgl = exec_tgl;

    bit_sync #(.W(3)) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .d        (sync_in),
        .q        (sync_q)
    );

    // Header and instruction words are held by the link long after the toggle
    assign pin_hi  = sync_q.pin_n;
    assign hdr_ev  = sync_q.hdr_tgl != st.hdr_seen;
    assign exec_ev = sync_q.exec_tgl != st.exec_seen;
    assign run_ev  = exec_ev && !pin_hi && st.prog_en && (st.state == CORE_IDLE);

    assign rd_addr    = {st.ext_addr, hdr.b2, hdr.b3};
    assign wr_addr    = {st.ext_addr, instr.hdr.b2, instr.hdr.b3};
    assign ee_rd_addr = EE_AW'({hdr.b2, hdr.b3});
    assign ee_wr_addr = EE_AW'({instr.hdr.b2, instr.hdr.b3});
    assign fl_rd_word = flash_mem[rd_addr[FLASH_AW-1:0]];

    // Answer for the fourth byte, chosen from the first three
    always_comb
    begin
        resp_val = NO_DATA;
        if (hdr.b1 == OP_POLL)
            resp_val = {7'h00, st.busy};
        else if (st.prog_en)
        begin
            if (hdr.b1 == OP_RD_HI)
                resp_val = fl_rd_word[15:8];
            else if (hdr.b1 == OP_RD_LO)
                resp_val = fl_rd_word[7:0];
            else if (hdr.b1 == OP_RD_EE)
                resp_val = ee_mem[ee_rd_addr];
            else if (hdr.b1 == OP_RD_CAL)
                resp_val = CALIBRATION;
            else if (hdr.b1 == OP_RD_SIG)
            begin
                case (hdr.b3[1:0])
                    2'h0:    resp_val = SIGNATURE[7:0];
                    2'h1:    resp_val = SIGNATURE[15:8];
                    2'h2:    resp_val = SIGNATURE[23:16];
                    default: resp_val = NO_DATA;
                endcase
            end
            else if (hdr.b1 == OP_RD_LOCK_FHI)
                resp_val = (hdr.b2 == SUB_FUSE_UPPER) ? st.fuse_hi : st.lock;
            else if (hdr.b1 == OP_RD_FUSE)
                resp_val = (hdr.b2 == SUB_FUSE_UPPER) ? st.fuse_ext : st.fuse_lo;
        end
    end

    always_comb
    begin
        next_st           = st;
        fbuf_lo_we        = 1'b0;
        fbuf_hi_we        = 1'b0;
        fl_page_we        = 1'b0;
        ee_we             = 1'b0;
        eebuf_we          = 1'b0;
        ee_page_we        = 1'b0;
        erase_we          = 1'b0;
        next_st.out_en    = !pin_hi;
        next_st.hdr_seen  = sync_q.hdr_tgl;
        next_st.exec_seen = sync_q.exec_tgl;

        // Self-timed operations; erase walks one location per cycle
        case (st.state)
            CORE_TIMED:
            begin
                if (st.wait_cnt == '0)
                    next_st.state = CORE_IDLE;
                else
                    next_st.wait_cnt = st.wait_cnt - 1'b1;
            end
            CORE_ERASE:
            begin
                erase_we = 1'b1;
                if (st.erase_ptr != ERASE_LAST)
                    next_st.erase_ptr = st.erase_ptr + 1'b1;
                if (st.wait_cnt != '0)
                    next_st.wait_cnt = st.wait_cnt - 1'b1;
                if (st.erase_ptr == ERASE_LAST && st.wait_cnt == '0)
                    next_st.state = CORE_IDLE;
            end
            default:
            begin
            end
        endcase

        if (hdr_ev)
            next_st.resp = resp_val;

        if (pin_hi)
            next_st.prog_en = 1'b0;
        else if (exec_ev && instr.hdr.b1 == OP_CTRL && instr.hdr.b2 == SUB_ENABLE)
            next_st.prog_en = 1'b1;
        else if (run_ev)
        begin
            // Writes issued while busy are dropped rather than corrupting
            if (instr.hdr.b1 == OP_LD_EXT)
                next_st.ext_addr = instr.hdr.b3;
            else if (instr.hdr.b1 == OP_LD_HI)
                fbuf_hi_we = 1'b1;
            else if (instr.hdr.b1 == OP_LD_LO)
                fbuf_lo_we = 1'b1;
            else if (instr.hdr.b1 == OP_LD_EE_PAGE)
                eebuf_we = 1'b1;
            else if (instr.hdr.b1 == OP_WR_PAGE)
            begin
                fl_page_we       = 1'b1;
                next_st.state    = CORE_TIMED;
                next_st.wait_cnt = WAIT_W'(FLASH_WAIT - 1);
            end
            else if (instr.hdr.b1 == OP_WR_EE || instr.hdr.b1 == OP_WR_EE_PAGE)
            begin
                ee_we            = instr.hdr.b1 == OP_WR_EE;
                ee_page_we       = instr.hdr.b1 == OP_WR_EE_PAGE;
                next_st.state    = CORE_TIMED;
                next_st.wait_cnt = WAIT_W'(EEPROM_WAIT - 1);
            end
            else if (instr.hdr.b1 == OP_CTRL)
            begin
                if (instr.hdr.b2 == SUB_ERASE)
                begin
                    next_st.state     = CORE_ERASE;
                    next_st.erase_ptr = '0;
                    next_st.wait_cnt  = WAIT_W'(ERASE_WAIT - 1);
                    next_st.lock      = ERASED_BYTE;
                end
                else if (instr.hdr.b2 == SUB_WR_LOCK || instr.hdr.b2 == SUB_WR_FUSE_LO
                         || instr.hdr.b2 == SUB_WR_FUSE_HI || instr.hdr.b2 == SUB_WR_FUSE_EX)
                begin
                    if (instr.hdr.b2 == SUB_WR_LOCK)
                        next_st.lock = instr.b4;
                    else if (instr.hdr.b2 == SUB_WR_FUSE_LO)
                        next_st.fuse_lo = instr.b4;
                    else if (instr.hdr.b2 == SUB_WR_FUSE_HI)
                        next_st.fuse_hi = instr.b4;
                    else
                        next_st.fuse_ext = instr.b4;
                    next_st.state    = CORE_TIMED;
                    next_st.wait_cnt = WAIT_W'(FLASH_WAIT - 1);
                end
            end
            // Anything else falls through untouched
        end

        next_st.busy = next_st.state != CORE_IDLE;
    end

    // Fuses come back to their start values on core reset only
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st          <= '0;
            st.state    <= CORE_IDLE;
            st.lock     <= LOCK_INIT;
            st.fuse_lo  <= FUSE_LO_INIT;
            st.fuse_hi  <= FUSE_HI_INIT;
            st.fuse_ext <= FUSE_EXT_INIT;
        end
        else
            st <= next_st;
    end

    // Page buffers; unloaded flash words stay erased and unloaded EEPROM bytes are skipped, so a partial page is safe
    always_ff @(posedge core_clk)
    begin
        if (reset || fl_page_we)
        begin
            for (int k = 0; k < PAGE_WORDS; k++)
                fbuf[k] <= ERASED_WORD;
        end
        else if (fbuf_lo_we)
            fbuf[instr.hdr.b3[PAGE_AW-1:0]][7:0] <= instr.b4;
        else if (fbuf_hi_we)
            fbuf[instr.hdr.b3[PAGE_AW-1:0]][15:8] <= instr.b4;
        if (reset || ee_page_we)
            eebuf_vld <= '0;
        else if (eebuf_we)
        begin
            eebuf[instr.hdr.b3[EE_PAGE_AW-1:0]]     <= instr.b4;
            eebuf_vld[instr.hdr.b3[EE_PAGE_AW-1:0]] <= 1'b1;
        end
    end

    // Arrays; an EEPROM write replaces the byte, erase included
    always_ff @(posedge core_clk)
    begin
        if (erase_we)
        begin
            flash_mem[st.erase_ptr[FLASH_AW-1:0]] <= ERASED_WORD;
            if (st.erase_ptr < EE_LIMIT)
                ee_mem[st.erase_ptr[EE_AW-1:0]] <= ERASED_BYTE;
        end
        if (fl_page_we)
        begin
            for (int k = 0; k < PAGE_WORDS; k++)
                flash_mem[{wr_addr[FLASH_AW-1:PAGE_AW], PAGE_AW'(k)}] <= fbuf[k];
        end
        if (ee_we)
            ee_mem[ee_wr_addr] <= instr.b4;
        if (ee_page_we)
        begin
            for (int k = 0; k < EE_PAGE_BYTES; k++)
                if (eebuf_vld[k])
                    ee_mem[{ee_wr_addr[EE_AW-1:EE_PAGE_AW], EE_PAGE_AW'(k)}] <= eebuf[k];
        end
    end

    assign serial_data_out_en = st.out_en;
    assign prog_enabled       = st.prog_en;
    assign ready_busy_flag    = st.busy;
    assign clock_source_fuses = st.fuse_lo[3:0];
    assign lock_bits          = st.lock;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    property p_pin_mode;
        pin_hi |=> !st.prog_en && !serial_data_out_en;
    endproperty
    a_pin_mode: assert property (p_pin_mode) else $error("active with reset pin high");

    property p_gate;
        !st.prog_en && st.state == CORE_IDLE |=> st.state == CORE_IDLE && $stable(st.ext_addr);
    endproperty
    a_gate: assert property (p_gate) else $error("operation before enable");

    property p_ee_write;
        run_ev && instr.hdr.b1 == OP_WR_EE
            |=> ee_mem[$past(ee_wr_addr)] == $past(instr.b4) && st.busy;
    endproperty
    a_ee_write: assert property (p_ee_write) else $error("EEPROM byte not written");

    property p_erase;
        erase_we |=> flash_mem[$past(st.erase_ptr[FLASH_AW-1:0])] == ERASED_WORD;
    endproperty
    a_erase: assert property (p_erase) else $error("erase left data");

    property p_ext_hold;
        exec_ev && instr.hdr.b1 != OP_LD_EXT |=> $stable(st.ext_addr);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("extended byte changed");

    property p_read_hi;
        hdr_ev && st.prog_en && hdr.b1 == OP_RD_HI |=> st.resp == $past(fl_rd_word[15:8]);
    endproperty
    a_read_hi: assert property (p_read_hi) else $error("flash read wrong");

    property p_poll;
        hdr_ev && hdr.b1 == OP_POLL |=> st.resp == {7'h00, $past(st.busy)};
    endproperty
    a_poll: assert property (p_poll) else $error("poll status wrong");

    property p_enable;
        exec_ev && !pin_hi && instr.hdr.b1 == OP_CTRL && instr.hdr.b2 == SUB_ENABLE
            |=> st.prog_en;
    endproperty
    a_enable: assert property (p_enable) else $error("enable not taken");

    property p_load_lo;
        run_ev && instr.hdr.b1 == OP_LD_LO
            |=> fbuf[$past(instr.hdr.b3[PAGE_AW-1:0])][7:0] == $past(instr.b4);
    endproperty
    a_load_lo: assert property (p_load_lo) else $error("page low byte not loaded");

    property p_page_busy;
        run_ev && instr.hdr.b1 == OP_WR_PAGE |=> st.busy && ready_busy_flag;
    endproperty
    a_page_busy: assert property (p_page_busy) else $error("page write not busy");

    property p_fuse_hi;
        run_ev && instr.hdr.b1 == OP_CTRL && instr.hdr.b2 == SUB_WR_FUSE_HI
            |=> st.fuse_hi == $past(instr.b4);
    endproperty
    a_fuse_hi: assert property (p_fuse_hi) else $error("high fuse not written");
endmodule // isp_engine

// ===== dv/isp_programmer.sv
module isp_programmer
(
    // Serial pins toward the device
    output logic      serial_clk,
    output logic      reset_pin_n,
    output logic      serial_data_in,
    input  wire logic serial_data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        serial_clk     = 1'b0;
        reset_pin_n    = 1'b1;
        serial_data_in = 1'b0;
    end

    // Clock stands still between frames; long highs give the core time to answer
    task automatic xfer(input logic [31:0] c, output logic [31:0] r);
        for (int i = 31; i >= 0; i--)
        begin
            serial_data_in = c[i];
            #16;
            r[i]       = serial_data_out;
            serial_clk = 1'b1;
            #((i == 8 || i == 0) ? 100 : 16);
            serial_clk = 1'b0;
        end
        serial_data_in = ~serial_data_in;
    endtask

    task automatic pin_level(input logic level);
        reset_pin_n = level;
        #100;
    endtask
endmodule // isp_programmer

// ===== dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import isp_pkg::*;

    // Identity values are arbitrary
    localparam logic [23:0] SIG = 24'h5A3C96;
    localparam logic [7:0]  CAL = 8'h80;
    localparam logic [7:0]  WSUB [4] = '{8'hE0, 8'hA0, 8'hA8, 8'hA4};
    localparam logic [15:0] RSEL [4] = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};

    logic        core_clk, reset, serial_clk, reset_pin_n, serial_data_in, serial_data_out;
    logic        serial_data_out_en, prog_enabled, ready_busy_flag;
    logic [3:0]  clock_source_fuses;
    logic [7:0]  lock_bits;
    logic [31:0] rsp;
    int          n_mismatch, total_checks;

    isp_engine #(.FLASH_AW(9), .FLASH_WAIT(400), .EEPROM_WAIT(800), .ERASE_WAIT(800),
        .SIGNATURE(SIG)) dut (.core_clk(core_clk), .reset(reset),
        .serial_clk(serial_clk), .reset_pin_n(reset_pin_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
        .prog_enabled(prog_enabled), .ready_busy_flag(ready_busy_flag),
        .clock_source_fuses(clock_source_fuses), .lock_bits(lock_bits));

    isp_programmer prog (.serial_clk(serial_clk), .reset_pin_n(reset_pin_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmd(input logic [31:0] c);
        prog.xfer(c, rsp);
    endtask

    // Busy must show at once, then clear within a bounded number of polls
    task automatic wait_ready();
        int n;
        n = 0;
        repeat (6) @(posedge core_clk);
        check("busy_pin", {7'h0, ready_busy_flag}, 8'h01);
        cmd(32'hF000_0000);
        check("poll_busy", rsp[7:0], 8'h01);
        while (rsp[0] !== 1'b0 && n < 60)
        begin
            cmd(32'hF000_0000);
            n++;
        end
        check("poll_ready", rsp[7:0], 8'h00);
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial
    begin
        #500000;
        n_mismatch++;
        test_done();
    end

    initial
    begin
        logic [7:0]  v, ix, lo, hi;
        logic [10:0] ea;
        void'($urandom(75939));
        reset = 1'b1;
        repeat (5) @(posedge core_clk);
        #1 reset = 1'b0;
        prog.pin_level(1'b0);
        check("out_en", {7'h0, serial_data_out_en}, 8'h01);
        cmd(32'hACA0_0000);
        cmd(32'h5000_0000);
        check("pre_en_rd", rsp[7:0], 8'h00);
        check("pre_en_fuse", {4'h0, clock_source_fuses}, 8'h0F);
        cmd(32'hAC53_0000);
        check("echo", rsp[15:8], 8'h53);
        repeat (6) @(posedge core_clk);
        check("enabled", {7'h0, prog_enabled}, 8'h01);
        for (int k = 0; k < 4; k++)
        begin
            v = (k == 1) ? 8'h00 : 8'($urandom);
            cmd({8'hAC, WSUB[k], 8'h00, v});
            wait_ready();
            cmd({RSEL[k], 16'h0000});
            check("cfg_rd", rsp[7:0], v);
            if (k == 0) check("lock_pin", lock_bits, v);
            if (k == 1) check("cksrc", {4'h0, clock_source_fuses}, {4'h0, v[3:0]});
        end
        ea = 11'($urandom);
        v = 8'($urandom);
        cmd({8'hC0, 5'h00, ea, v});
        wait_ready();
        cmd({8'hA0, 5'h00, ea, 8'h00});
        check("ee_rd", rsp[7:0], v);
        v = ~v;
        cmd({16'hC100, 6'h00, ea[1:0], v});
        cmd({8'hC2, 5'h00, ea[10:2], 2'h0, 8'h00});
        wait_ready();
        cmd({8'hA0, 5'h00, ea, 8'h00});
        check("ee_page", rsp[7:0], v);
        ix = {1'b0, 7'($urandom)};
        lo = 8'($urandom);
        hi = 8'($urandom);
        cmd(32'h4D00_0000);
        cmd({16'h4000, ix, lo});
        cmd({16'h4800, ix, hi});
        cmd({16'h4C01, ix, 8'h00});
        wait_ready();
        cmd({16'h2001, ix, 8'h00});
        check("fl_lo", rsp[7:0], lo);
        cmd({8'h12, 8'h01, ix, 8'hAA});
        cmd({16'h2801, ix, 8'h00});
        check("fl_hi", rsp[7:0], hi);
        cmd(32'hAC80_0000);
        wait_ready();
        cmd({16'h2001, ix, 8'h00});
        check("erase_fl", rsp[7:0], 8'hFF);
        cmd({8'hA0, 5'h00, ea, 8'h00});
        check("erase_ee", rsp[7:0], 8'hFF);
        cmd(32'h3000_0000);
        check("sig", rsp[7:0], SIG[7:0]);
        cmd(32'h3800_0000);
        check("cal", rsp[7:0], CAL);
        prog.pin_level(1'b1);
        check("pin_exit", {7'h0, prog_enabled}, 8'h00);
        test_done();
    end
endmodule // testbench
